//--- logic/fseq_defines.svh
/*
 Register offsets, field positions, reset values and timing figures of the
 flash self erase/program sequencer. Definitions only; included by the package.
*/
`ifndef FSEQ_DEFINES_SVH
`define FSEQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define FSEQ_OFS_PTR      8'h00
`define FSEQ_OFS_LATCH    8'h04
`define FSEQ_OFS_TBLWR    8'h08
`define FSEQ_OFS_CTRL     8'h0C
`define FSEQ_OFS_KEY      8'h10
`define FSEQ_OFS_STATUS   8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FSEQ_CTRL_START   1
`define FSEQ_CTRL_WRITE_ENABLE_BIT    2
`define FSEQ_CTRL_ABORT   3
`define FSEQ_CTRL_ERASE   4
`define FSEQ_PTR_W        22
`define FSEQ_PTR_INC_W    21
`define FSEQ_ROW_BYTES    64
`define FSEQ_IDX_W        6
`define FSEQ_BLK_LSB      10
`define FSEQ_ROW_LSB      6

// ----------------------------------------------------------------------------
// Key values, reset values, timing
// ----------------------------------------------------------------------------
`define FSEQ_KEY_FIRST    8'h55
`define FSEQ_KEY_SECOND   8'hAA
`define FSEQ_PTR_RST      22'h00_0000
`define FSEQ_BYTE_RST     8'h00
`define FSEQ_CLK_KHZ      40000
`define FSEQ_PROG_TIME_US 2000
`define FSEQ_ERASE_TIME_US 2000

`endif

//--- logic/fseq_pkg.sv
/*
 Types of the flash self erase/program sequencer.
 Assumes fseq_defines.svh is on the include path.
*/
`include "fseq_defines.svh"

package fseq_pkg;

   // --------------------------------------------------------------------------
   // Operation state, one bit from idle to erase, both bits from idle to program
   // --------------------------------------------------------------------------
   typedef enum logic [1:0] {
      FSEQ_IDLE  = 2'b00,
      FSEQ_ERASE = 2'b01,
      FSEQ_PROG  = 2'b11
   } fseq_op_t;

   typedef enum logic [1:0] {
      FSEQ_KEY_NONE = 2'b00,
      FSEQ_KEY_55   = 2'b01,
      FSEQ_KEY_AA   = 2'b11
   } fseq_key_t;

   // --------------------------------------------------------------------------
   // Flash array command carrier
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic erase;
      logic prog;
      logic [11:0] block;
      logic [14:0] row;
      logic [`FSEQ_ROW_BYTES-1:0][7:0] data;
   } fseq_flash_t;

   // --------------------------------------------------------------------------
   // Whole module state
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic awseen;
      logic [7:0] awaddr;
      logic wseen;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [`FSEQ_PTR_W-1:0] ptr;
      logic [7:0] latch;
      logic erase_sel;
      logic abort;
      logic write_enable_bit;
      logic start;
      fseq_key_t key;
      fseq_op_t op;
      logic [31:0] timer;
      logic [`FSEQ_ROW_BYTES-1:0][7:0] hold;
      fseq_flash_t flash;
   } fseq_state_t;

endpackage

//--- logic/fseq_seq.sv
/*
 Flash self erase/program sequencer with an AXI4-Lite register slave.
 Assumes one clock (aclk, 40 MHz), synchronous active-low reset, and a flash
 array that acts on the erase/prog levels for as long as they stand.
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module fseq_seq
   import fseq_pkg::*;
#(
   parameter int PROG_CYCLES = `FSEQ_PROG_TIME_US * (`FSEQ_CLK_KHZ / 1000),
   parameter int ERASE_CYCLES = `FSEQ_ERASE_TIME_US * (`FSEQ_CLK_KHZ / 1000)
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Warm reset event from the reset controller, same clock
   input wire logic warm_reset,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // CPU and flash array
   output logic cpu_stall,
   output fseq_flash_t flash_cmd
);

   // ---------------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------------
   // Byte-lane merge keeps the pointer bytes that the strobes leave out
   function automatic logic [31:0] fseq_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Only whole aligned words are decoded; any other offset gets an error response
   function automatic logic fseq_mapped(input logic [7:0] a);
      return (a == `FSEQ_OFS_PTR) || (a == `FSEQ_OFS_LATCH) || (a == `FSEQ_OFS_TBLWR) ||
             (a == `FSEQ_OFS_CTRL) || (a == `FSEQ_OFS_KEY) || (a == `FSEQ_OFS_STATUS);
   endfunction

   localparam logic [31:0] PROG_CNT = PROG_CYCLES[31:0];
   localparam logic [31:0] ERASE_CNT = ERASE_CYCLES[31:0];

   fseq_state_t s_q, s_d;

   // ---------------------------------------------------------------------------
   // Bus handshakes
   // ---------------------------------------------------------------------------
   // Address and data are taken in either order; the response waits for both.
   // One write and one read at most are under way; a second waits for the answer.
   assign awready = !s_q.awseen && !s_q.bvalid;
   assign wready = !s_q.wseen && !s_q.bvalid;
   assign arready = !s_q.rvalid;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign cpu_stall = (s_q.op != FSEQ_IDLE);
   assign flash_cmd = s_q.flash;

   // ---------------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------------
   always_comb begin
      logic [31:0] wd;
      logic [31:0] ptrw;
      logic [7:0] a;
      logic do_wr;
      logic [`FSEQ_PTR_INC_W-1:0] low;
      wd = 32'h0000_0000;
      ptrw = 32'h0000_0000;
      a = 8'h00;
      do_wr = 1'b0;
      low = '0;
      s_d = s_q;
      // Bus capture, register write, timer, warm reset: a later step overrides an earlier one

      if (awvalid && awready) begin
         s_d.awseen = 1'b1;
         s_d.awaddr = awaddr;
      end
      if (wvalid && wready) begin
         s_d.wseen = 1'b1;
         s_d.wdata = wdata;
         s_d.wstrb = wstrb;
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end

      // Register write once both halves are in
      if (s_q.awseen && s_q.wseen) begin
         do_wr = 1'b1;
         a = s_q.awaddr;
         wd = s_q.wdata;
         s_d.awseen = 1'b0;
         s_d.wseen = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = fseq_mapped(a) ? 2'b00 : 2'b10;
      end

      // Any write other than the key sequence breaks the unlock
      if (do_wr && a != `FSEQ_OFS_KEY) begin
         s_d.key = FSEQ_KEY_NONE;
      end

      if (do_wr && s_q.op == FSEQ_IDLE) begin
         unique case (a)
            `FSEQ_OFS_PTR: begin
               ptrw = fseq_merge({10'h000, s_q.ptr}, wd, s_q.wstrb);
               s_d.ptr = ptrw[`FSEQ_PTR_W-1:0];
            end
            `FSEQ_OFS_LATCH: begin
               if (s_q.wstrb[0]) begin
                  s_d.latch = wd[7:0];
               end
            end
            `FSEQ_OFS_TBLWR: begin
               // Mode: 0 keep, 1 post-increment, 2 post-decrement, 3 pre-increment
               // Only the low 21 pointer bits move; the top bit selects a separate space
               if (s_q.wstrb[0]) begin
                  low = s_q.ptr[`FSEQ_PTR_INC_W-1:0];
                  if (wd[1:0] == 2'b11) begin
                     low = low + 21'h00_0001;
                  end
                  s_d.hold[low[`FSEQ_IDX_W-1:0]] = s_q.latch;
                  if (wd[1:0] == 2'b01) begin
                     low = low + 21'h00_0001;
                  end else if (wd[1:0] == 2'b10) begin
                     low = low - 21'h00_0001;
                  end
                  s_d.ptr[`FSEQ_PTR_INC_W-1:0] = low;
               end
            end
            `FSEQ_OFS_CTRL: begin
               if (s_q.wstrb[0]) begin
                  s_d.write_enable_bit = wd[`FSEQ_CTRL_WRITE_ENABLE_BIT];
                  s_d.erase_sel = wd[`FSEQ_CTRL_ERASE];
                  // The clear comes first so a refused start in the same write still sets the flag
                  if (!wd[`FSEQ_CTRL_ABORT]) begin
                     s_d.abort = 1'b0;
                  end
                  // Writing zero to start never clears it
                  if (wd[`FSEQ_CTRL_START]) begin
                     if (s_q.key == FSEQ_KEY_AA && wd[`FSEQ_CTRL_WRITE_ENABLE_BIT]) begin
                        s_d.start = 1'b1;
                        s_d.flash.block = s_q.ptr[`FSEQ_PTR_W-1:`FSEQ_BLK_LSB];
                        s_d.flash.row = s_q.ptr[20:`FSEQ_ROW_LSB];
                        s_d.flash.data = s_q.hold;
                        if (wd[`FSEQ_CTRL_ERASE]) begin
                           s_d.op = FSEQ_ERASE;
                           s_d.timer = ERASE_CNT;
                           s_d.flash.erase = 1'b1;
                        end else begin
                           s_d.op = FSEQ_PROG;
                           s_d.timer = PROG_CNT;
                           s_d.flash.prog = 1'b1;
                        end
                     end else begin
                        s_d.abort = 1'b1;
                     end
                  end
               end
            end
            `FSEQ_OFS_KEY: begin
               // A stray value drops the unlock so a runaway loop cannot start a cycle
               if (s_q.wstrb[0] && wd[7:0] == `FSEQ_KEY_FIRST) begin
                  s_d.key = FSEQ_KEY_55;
               end else if (s_q.wstrb[0] && wd[7:0] == `FSEQ_KEY_SECOND && s_q.key == FSEQ_KEY_55) begin
                  s_d.key = FSEQ_KEY_AA;
               end else begin
                  s_d.key = FSEQ_KEY_NONE;
               end
            end
            default: begin
            end
         endcase
      end

      // Self-timed cycle; the timer or a warm reset ends it
      // Loaded by the start write, so the stall lasts exactly the count
      if (s_q.op != FSEQ_IDLE) begin
         s_d.timer = s_q.timer - 32'h0000_0001;
         if (s_q.timer <= 32'h0000_0001) begin
            s_d.op = FSEQ_IDLE;
            s_d.start = 1'b0;
            s_d.flash.erase = 1'b0;
            s_d.flash.prog = 1'b0;
            // A finished program leaves erase select alone; a finished erase clears it
            if (s_q.op == FSEQ_ERASE) begin
               s_d.erase_sel = 1'b0;
            end
         end
      end

      // A warm reset kills the cycle and leaves the abort flag for software
      // Pointer and holding registers survive it, so software may simply retry
      if (warm_reset) begin
         if (s_q.op != FSEQ_IDLE) begin
            s_d.abort = 1'b1;
         end
         s_d.op = FSEQ_IDLE;
         s_d.start = 1'b0;
         s_d.write_enable_bit = 1'b0;
         s_d.erase_sel = 1'b0;
         s_d.key = FSEQ_KEY_NONE;
         s_d.flash.erase = 1'b0;
         s_d.flash.prog = 1'b0;
      end

      // ------------------------------------------------------------------------
      // Read path; reads are answered even while a long cycle runs
      // ------------------------------------------------------------------------
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = fseq_mapped(araddr) ? 2'b00 : 2'b10;
         s_d.rdata = 32'h0000_0000;
         unique case (araddr)
            `FSEQ_OFS_PTR: s_d.rdata = {10'h000, s_q.ptr};
            `FSEQ_OFS_LATCH: s_d.rdata = {24'h00_0000, s_q.latch};
            `FSEQ_OFS_CTRL: s_d.rdata = {27'h000_0000, s_q.erase_sel, s_q.abort, s_q.write_enable_bit, s_q.start, 1'b0};
            `FSEQ_OFS_STATUS: s_d.rdata = {28'h000_0000, s_q.key, s_q.op};
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------------------
   // Holding registers clear too; software still reloads them before each program
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.ptr <= `FSEQ_PTR_RST;
         s_q.latch <= `FSEQ_BYTE_RST;
         s_q.op <= FSEQ_IDLE;
         s_q.key <= FSEQ_KEY_NONE;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // fseq_seq

`default_nettype wire

//--- tb/flash_self_erase_program_seq_tb.sv
/*
 Self-checking bench of the flash sequencer: register writes, unlock, cycles.
 Assumes fseq_cpu_model as bus master and short cycle counts.
*/
`include "fseq_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_self_erase_program_seq_tb import fseq_pkg::*; ;
   localparam int PC = 20;
   localparam int EC = 24;
   localparam logic [7:0] PTR = `FSEQ_OFS_PTR;
   localparam logic [7:0] LAT = `FSEQ_OFS_LATCH;
   localparam logic [7:0] TBW = `FSEQ_OFS_TBLWR;
   localparam logic [7:0] CTRL = `FSEQ_OFS_CTRL;
   localparam logic [7:0] KEY = `FSEQ_OFS_KEY;
   localparam logic [7:0] STA = `FSEQ_OFS_STATUS;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic warm_reset = 1'b0;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, cpu_stall;
   logic [7:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, rdat;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   fseq_flash_t flash_cmd;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   always #12.5 aclk = ~aclk;
   fseq_seq #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .warm_reset(warm_reset), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .cpu_stall(cpu_stall), .flash_cmd(flash_cmd));
   fseq_cpu_model u_cpu (
      .aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      u_cpu.wr(a, d, rsp);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      u_cpu.rd(a, rdat, rsp);
      chk(rdat, e);
      chk(rsp, 2'b00);
   endtask
   task automatic unlock;
      w(KEY, 8'h55);
      w(KEY, 8'hAA);
   endtask
   // Checks the command one cycle into the stall, then times the stall
   task automatic op(input logic er, input logic [21:0] p, input int len);
      int n;
      n = 0;
      @(negedge aclk);
      chk(cpu_stall, 1'b1);
      chk(flash_cmd.erase, er);
      chk(flash_cmd.prog, !er);
      chk(flash_cmd.block, p[21:10]);
      if (!er) begin
         chk(flash_cmd.row, p[20:6]);
         for (int i = 0; i < 64; i++) chk(flash_cmd.data[i], 8'h80 + i);
      end
      while (cpu_stall && n < 1000) begin
         @(negedge aclk);
         n++;
      end
      // The stall began one cycle before the first negedge looked at it
      chk(32'(n + 1), 32'(len));
   endtask
   task automatic results;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard, far above the fewer than one thousand cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(CTRL, 8'h00);
      rdc(PTR, 8'h00);
      u_cpu.rd(8'h18, rdat, rsp);
      chk(rsp, 2'b10);
      chk(rdat, 8'h00);
      u_cpu.wr(8'h1C, 8'h01, rsp);
      chk(rsp, 2'b10);
      w(PTR, 22'h00_1040);
      w(TBW, 2'h3);
      rdc(PTR, 22'h00_1041);
      w(TBW, 2'h2);
      rdc(PTR, 22'h00_1040);
      w(TBW, 2'h0);
      rdc(PTR, 22'h00_1040);
      w(PTR, 22'h3F_FFFF);
      w(TBW, 2'h1);
      rdc(PTR, 22'h20_0000);
      w(PTR, 22'h00_1040);
      for (int i = 0; i < 64; i++) begin
         w(LAT, 8'h80 + i);
         w(TBW, 2'h1);
      end
      rdc(PTR, 22'h00_1080);
      chk(cpu_stall, 1'b0);
      w(CTRL, 8'h06);
      rdc(CTRL, 8'h0C);
      w(CTRL, 8'h00);
      unlock();
      rdc(STA, 8'h0C);
      w(PTR, 22'h00_1045);
      w(CTRL, 8'h06);
      rdc(CTRL, 8'h0C);
      w(CTRL, 8'h00);
      unlock();
      w(CTRL, 8'h02);
      rdc(CTRL, 8'h08);
      w(CTRL, 8'h00);
      unlock();
      w(CTRL, 8'h06);
      op(1'b0, 22'h00_1045, PC);
      rdc(CTRL, 8'h04);
      w(PTR, 22'h00_13FF);
      w(CTRL, 8'h14);
      unlock();
      w(CTRL, 8'h16);
      op(1'b1, 22'h00_13FF, EC);
      rdc(CTRL, 8'h04);
      w(PTR, 22'h00_1070);
      unlock();
      w(CTRL, 8'h06);
      op(1'b0, 22'h00_1070, PC);
      unlock();
      w(CTRL, 8'h06);
      @(posedge aclk);
      warm_reset <= 1'b1;
      @(posedge aclk);
      warm_reset <= 1'b0;
      @(negedge aclk);
      chk(cpu_stall, 1'b0);
      rdc(CTRL, 8'h08);
      results();
   end
endmodule // flash_self_erase_program_seq_tb
`default_nettype wire

//--- tb/fseq_cpu_model.sv
/*
 Bus-master model of the CPU core issuing register writes and reads.
 Assumes the AXI4-Lite slave of fseq_seq on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fseq_cpu_model (
   // Clock
   input wire logic aclk,
   // Write address and data
   output logic awvalid,
   input wire logic awready,
   output logic [7:0] awaddr,
   output logic [2:0] awprot,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   // Write response
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   // Read
   output logic arvalid,
   input wire logic arready,
   output logic [7:0] araddr,
   output logic [2:0] arprot,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   initial begin
      awvalid = 1'b0;
      awaddr = 8'h00;
      awprot = 3'h0;
      wvalid = 1'b0;
      wdata = 32'h0000_0000;
      wstrb = 4'hF;
      bready = 1'b0;
      arvalid = 1'b0;
      araddr = 8'h00;
      arprot = 3'h0;
      rready = 1'b0;
   end
   // Released payload is inverted so a late-sampling slave sees junk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (!w_done && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      araddr <= ~a;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // fseq_cpu_model
`default_nettype wire

//--- tb/fseq_seq_assertions.sv
/*
 Port checker of the flash sequencer, bound onto fseq_seq.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fseq_seq_checker
   import fseq_pkg::*;
#(
   parameter int PROG_CYCLES = 20,
   parameter int ERASE_CYCLES = 20
) (
   // Clock and resets
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic warm_reset,
   // Bus handshakes
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   // CPU and array
   input wire logic cpu_stall,
   input wire fseq_flash_t flash_cmd
);
   // ------------------------------------------------------------
   // Cycles of the running command, zero between commands
   // ------------------------------------------------------------
   logic [31:0] erase_len_q;
   logic [31:0] prog_len_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         erase_len_q <= 32'h0000_0000;
         prog_len_q <= 32'h0000_0000;
      end else begin
         erase_len_q <= flash_cmd.erase ? erase_len_q + 32'h0000_0001 : 32'h0000_0000;
         prog_len_q <= flash_cmd.prog ? prog_len_q + 32'h0000_0001 : 32'h0000_0000;
      end
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // A warm reset cuts a cycle short on purpose, so its end is not timed
   sequence s_erase_end;
      $fell(flash_cmd.erase) && !$past(warm_reset);
   endsequence
   sequence s_prog_end;
      $fell(flash_cmd.prog) && !$past(warm_reset);
   endsequence
   chk_erase_len: assert property (s_erase_end |-> erase_len_q == ERASE_CYCLES)
      else $error("erase length wrong");
   chk_prog_len: assert property (s_prog_end |-> prog_len_q == PROG_CYCLES)
      else $error("program length wrong");
   chk_stall_op: assert property ((flash_cmd.erase || flash_cmd.prog) |-> cpu_stall)
      else $error("no stall during cycle");
   chk_one_op: assert property (!(flash_cmd.erase && flash_cmd.prog))
      else $error("erase and program together");
   chk_start_write: assert property ($rose(cpu_stall) |-> bvalid || $past(bvalid))
      else $error("cycle without a write");
   chk_block_row: assert property (cpu_stall |-> flash_cmd.block[10:0] == flash_cmd.row[14:4])
      else $error("block and row disagree");
   chk_block_hold: assert property (flash_cmd.erase ##1 flash_cmd.erase |-> $stable(flash_cmd.block))
      else $error("erase block moved");
   chk_warm_abort: assert property (warm_reset |=> !cpu_stall)
      else $error("warm reset kept cycle");
   chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   chk_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answering");
endmodule // fseq_seq_checker
bind fseq_seq fseq_seq_checker #(
   .PROG_CYCLES(PROG_CYCLES),
   .ERASE_CYCLES(ERASE_CYCLES)
) u_chk (
   .aclk(aclk), .aresetn(aresetn), .warm_reset(warm_reset), .awready(awready), .wready(wready),
   .bvalid(bvalid), .bready(bready), .bresp(bresp), .cpu_stall(cpu_stall), .flash_cmd(flash_cmd)
);
`default_nettype wire
